// *** hw/dts_sensor.v ***
// Temperature sensor digital core with SMBus slave and alarm outputs
`timescale 1ns/1ps
`default_nettype none
`include "dts_defs.vh"
module dts_sensor #(
    parameter [6:0]  DEV_ADDR    = 7'h4c, // Arbitrary slave address
    parameter        FAULT_ALERT = 1,
    parameter [31:0] TIMEOUT_CYC = `DTS_TIMEOUT_CYC,
    parameter [31:0] INTEG_CYC   = `DTS_INTEG_CYC,
    parameter [31:0] PERIOD_CYC  = `DTS_PERIOD_CYC
) (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_n_o,
    input  wire [11:0] local_temp_i,
    input  wire [11:0] remote_temp_i,
    input  wire        remote_fault_i,
    output reg         alert_o,
    output reg         alert_oe_n_o,
    output reg         overtemp_alarm_out_o,
    output reg         overtemp_alarm_out_oe_n_o
);
    // Temperature inputs: signed, 0.125 C per LSB, sign in bit 11
    reg  [2:0]  scl_s;
    reg  [2:0]  sda_s;
    wire        scl = scl_s[1];
    wire        sda = sda_s[1];
    wire        scl_rise = scl_s[1] & ~scl_s[2];
    wire        scl_fall = ~scl_s[1] & scl_s[2];
    wire        start_c = scl & scl_s[2] & ~sda & sda_s[2];
    wire        stop_c  = scl & scl_s[2] & sda & ~sda_s[2];

    localparam [5:0] S_IDLE = 6'h01, S_ADDR = 6'h02, S_AACK = 6'h04,
                     S_WR   = 6'h08, S_RD   = 6'h10, S_RACK = 6'h20;
    reg  [5:0]  state;
    reg  [3:0]  bitcnt;
    reg  [7:0]  shreg;
    reg         is_read;
    reg         ara_hit;
    reg         got_cmd;
    reg  [7:0]  cmd;
    reg  [31:0] low_cnt;

    reg  [7:0]  local_int, remote_int, local_frac, remote_frac;
    reg  [7:0]  cfg, rate;
    reg  [7:0]  lhigh, llow, rhigh, rlow, lover, rover;
    reg  [7:0]  status;
    reg         alert_latched;
    reg         one_shot_req;
    reg         ack_clear;

    // Saturate a signed 0.125 step reading to an 11-bit unsigned result
    function [10:0] to_result;
        input [11:0] t;
        begin
            if (t[11])
                to_result = 11'h000;
            else
                to_result = t[10:0];
        end
    endfunction

    function [7:0] reg_read;
        input [7:0] a;
        begin
            case (a)
                `DTS_REG_LOCAL_INT:   reg_read = local_int;
                `DTS_REG_REMOTE_INT:  reg_read = remote_int;
                `DTS_REG_REMOTE_FRAC: reg_read = remote_frac;
                `DTS_REG_LOCAL_FRAC:  reg_read = local_frac;
                `DTS_REG_STATUS:      reg_read = status;
                `DTS_REG_CONFIG:      reg_read = cfg;
                `DTS_REG_RATE:        reg_read = rate;
                `DTS_REG_LOCAL_HIGH:  reg_read = lhigh;
                `DTS_REG_LOCAL_LOW:   reg_read = llow;
                `DTS_REG_REMOTE_HIGH: reg_read = rhigh;
                `DTS_REG_REMOTE_LOW:  reg_read = rlow;
                `DTS_REG_LOCAL_OVER:  reg_read = lover;
                `DTS_REG_REMOTE_OVER: reg_read = rover;
                default:              reg_read = 8'h00;
            endcase
        end
    endfunction

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
        end
    end

    // SMBus slave
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            is_read <= 1'b0;
            ara_hit <= 1'b0;
            got_cmd <= 1'b0;
            cmd <= 8'h00;
            low_cnt <= 32'h0;
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
            cfg <= 8'h00;
            rate <= `DTS_RST_RATE;
            lhigh <= `DTS_RST_LOCAL_HIGH;
            rhigh <= `DTS_RST_REMOTE_HIGH;
            llow <= `DTS_RST_LOW;
            rlow <= `DTS_RST_LOW;
            lover <= `DTS_RST_OVER;
            rover <= `DTS_RST_OVER;
            one_shot_req <= 1'b0;
            ack_clear <= 1'b0;
        end else begin
            one_shot_req <= 1'b0;
            ack_clear <= 1'b0;
            if (scl)
                low_cnt <= 32'h0;
            else if (low_cnt != TIMEOUT_CYC)
                low_cnt <= low_cnt + 32'h1;
            if (!scl && low_cnt == TIMEOUT_CYC) begin
                state <= S_IDLE;
                sda_o <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_c) begin
                state <= S_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (start_c) begin
                state <= S_ADDR;
                bitcnt <= 4'h0;
                got_cmd <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: sda_oe_n_o <= 1'b1;
                    S_ADDR, S_WR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == S_ADDR) begin
                                if (shreg[7:1] == DEV_ADDR ||
                                    (shreg[7:1] == `DTS_ARA_ADDR &&
                                     shreg[0] && alert_latched)) begin
                                    ara_hit <= shreg[7:1] != DEV_ADDR;
                                    is_read <= shreg[0];
                                    sda_o <= 1'b0;
                                    sda_oe_n_o <= 1'b0;
                                    state <= S_AACK;
                                end else
                                    state <= S_IDLE;
                            end else begin
                                sda_o <= 1'b0;
                                sda_oe_n_o <= 1'b0;
                                state <= S_AACK;
                                is_read <= 1'b0;
                                if (!got_cmd) begin
                                    cmd <= shreg;
                                    got_cmd <= 1'b1;
                                    if (shreg == `DTS_REG_ONE_SHOT)
                                        one_shot_req <= 1'b1;
                                end else begin
                                    case (cmd)
                                        `DTS_REG_CONFIG: cfg <= shreg;
                                        `DTS_REG_RATE: rate <= shreg;
                                        `DTS_REG_LOCAL_HIGH: lhigh <= shreg;
                                        `DTS_REG_LOCAL_LOW: llow <= shreg;
                                        `DTS_REG_REMOTE_HIGH: rhigh <= shreg;
                                        `DTS_REG_REMOTE_LOW: rlow <= shreg;
                                        `DTS_REG_LOCAL_OVER: lover <= shreg;
                                        `DTS_REG_REMOTE_OVER: rover <= shreg;
                                        default: ;
                                    endcase
                                end
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                shreg <= ara_hit ? {DEV_ADDR, 1'b1}
                                                 : reg_read(cmd);
                                // Open drain: release for a one
                                sda_oe_n_o <= ara_hit ? DEV_ADDR[6]
                                              : (reg_read(cmd) >= 8'h80);
                                bitcnt <= 4'h1;
                                state <= S_RD;
                                if (ara_hit || cmd == `DTS_REG_STATUS)
                                    ack_clear <= 1'b1;
                            end else begin
                                sda_oe_n_o <= 1'b1;
                                state <= S_WR;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe_n_o <= 1'b1;
                                state <= S_RACK;
                            end else begin
                                sda_oe_n_o <= shreg[3'h7 - bitcnt[2:0]];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise)
                            state <= sda ? S_IDLE : S_AACK;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Conversion sequencer: remote then local integration
    localparam [2:0] C_IDLE = 3'h1, C_REM = 3'h2, C_LOC = 3'h4;
    reg  [2:0]  cstate;
    reg  [31:0] ccnt;
    reg  [31:0] pcnt;
    reg  [10:0] rem_res;
    reg         rem_flt;
    wire [10:0] loc_res = to_result(local_temp_i);
    wire        auto_go = !cfg[`DTS_CFG_STANDBY] &&
                          pcnt >= (PERIOD_CYC >> rate[3:0]);

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cstate <= C_IDLE;
            ccnt <= 32'h0;
            pcnt <= 32'h0;
            rem_res <= 11'h000;
            rem_flt <= 1'b0;
            local_int <= 8'h00;
            remote_int <= 8'h00;
            local_frac <= 8'h00;
            remote_frac <= 8'h00;
        end else begin
            pcnt <= auto_go ? 32'h0 : pcnt + 32'h1;
            case (cstate)
                C_IDLE: begin
                    if (auto_go || one_shot_req) begin
                        cstate <= C_REM;
                        ccnt <= 32'h0;
                    end
                end
                C_REM: begin
                    if (ccnt == INTEG_CYC - 32'h1) begin
                        rem_res <= to_result(remote_temp_i);
                        rem_flt <= remote_fault_i;
                        ccnt <= 32'h0;
                        cstate <= C_LOC;
                    end else
                        ccnt <= ccnt + 32'h1;
                end
                C_LOC: begin
                    if (ccnt == INTEG_CYC - 32'h1) begin
                        cstate <= C_IDLE;
                        local_int <= loc_res[10:3];
                        local_frac <= {loc_res[2:0], 5'h00};
                        remote_int <= rem_flt ? `DTS_FAULT_CODE
                                              : rem_res[10:3];
                        remote_frac <= rem_flt ? 8'h00
                                               : {rem_res[2:0], 5'h00};
                    end else
                        ccnt <= ccnt + 32'h1;
                end
                default: cstate <= C_IDLE;
            endcase
        end
    end

    // Limit comparisons on stored results
    wire lh = local_int >= lhigh;
    wire ll = local_int < llow;
    wire rf = remote_int == `DTS_FAULT_CODE;
    wire rh = !rf && remote_int >= rhigh;
    wire rl = !rf && remote_int < rlow;
    wire fault_alarm = FAULT_ALERT && rf;
    wire alarm_cause = lh | ll | rh | rl | fault_alarm;

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= 8'h00;
            alert_latched <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_n_o <= 1'b1;
            overtemp_alarm_out_o <= 1'b0;
            overtemp_alarm_out_oe_n_o <= 1'b1;
        end else begin
            status <= {cstate != C_IDLE, lh, ll, rh, rl, rf,
                       remote_int >= rover && !rf, local_int >= lover};
            if (alarm_cause)
                alert_latched <= 1'b1;
            else if (ack_clear)
                alert_latched <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_n_o <= !(alarm_cause | alert_latched);
            overtemp_alarm_out_o <= 1'b0;
            overtemp_alarm_out_oe_n_o <= !((local_int > lover) ||
                (!rf && remote_int > rover));
        end
    end
endmodule
`default_nettype wire

// *** hw/dts_defs.vh ***
// Constants for the dual channel temperature sensor logic
`ifndef DTS_DEFS_VH
`define DTS_DEFS_VH
`define DTS_REG_LOCAL_INT    8'h00
`define DTS_REG_REMOTE_INT   8'h01
`define DTS_REG_REMOTE_FRAC  8'h10
`define DTS_REG_LOCAL_FRAC   8'h11
`define DTS_REG_STATUS       8'h02
`define DTS_REG_CONFIG       8'h03
`define DTS_REG_RATE         8'h04
`define DTS_REG_LOCAL_HIGH   8'h05
`define DTS_REG_REMOTE_HIGH  8'h07
`define DTS_REG_LOCAL_LOW    8'h06
`define DTS_REG_REMOTE_LOW   8'h08
`define DTS_REG_ONE_SHOT     8'h0f
`define DTS_REG_LOCAL_OVER   8'h20
`define DTS_REG_REMOTE_OVER  8'h19
`define DTS_ARA_ADDR         7'h0c
`define DTS_FAULT_CODE       8'hff
`define DTS_RST_LOCAL_HIGH   8'h55
`define DTS_RST_REMOTE_HIGH  8'h5f
`define DTS_RST_LOW          8'h00
`define DTS_RST_OVER         8'h55
`define DTS_RST_RATE         8'h02
`define DTS_CLK_HZ           25000000
`define DTS_TIMEOUT_MS       25
`define DTS_INTEG_MS         60
`define DTS_TIMEOUT_CYC      ((`DTS_CLK_HZ / 1000) * `DTS_TIMEOUT_MS)
`define DTS_INTEG_CYC        ((`DTS_CLK_HZ / 1000) * `DTS_INTEG_MS)
`define DTS_PERIOD_CYC       (`DTS_INTEG_CYC * 4)
`define DTS_CFG_STANDBY      6
`define DTS_CFG_FAULT_ALRT   5
`define DTS_ST_BUSY          7
`define DTS_ST_LHIGH         6
`define DTS_ST_LLOW          5
`define DTS_ST_RHIGH         4
`define DTS_ST_RLOW          3
`define DTS_ST_OPEN          2
`define DTS_ST_ROVER         1
`define DTS_ST_LOVER         0
`endif

// *** tb/dts_sensor_chk.sv ***
// Port-level assertion checker for the temperature sensor core
`timescale 1ns/1ps
`default_nettype none
module dts_sensor_chk #(
    parameter [31:0] TIMEOUT_CYC = 2000,
    parameter        FAULT_ALERT = 1
) (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_n_o,
    input wire logic [11:0] local_temp_i,
    input wire logic [11:0] remote_temp_i,
    input wire logic        remote_fault_i,
    input wire logic        alert_o,
    input wire logic        alert_oe_n_o,
    input wire logic        overtemp_alarm_out_o,
    input wire logic        overtemp_alarm_out_oe_n_o
);
    int   low_cnt;
    int   hi_cnt;
    int   quiet_cnt;
    int   fault_cnt;
    logic scl_q;
    function automatic int sat(input int c, input logic en);
        return en ? ((c < 100000) ? c + 1 : c) : 0;
    endfunction
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            low_cnt <= 0;
            hi_cnt <= 0;
            quiet_cnt <= 0;
            fault_cnt <= 0;
        end else begin
            scl_q <= scl_i;
            low_cnt <= sat(low_cnt, !scl_i);
            hi_cnt <= sat(hi_cnt, scl_i);
            quiet_cnt <= sat(quiet_cnt, scl_i == scl_q);
            fault_cnt <= sat(fault_cnt, remote_fault_i);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_stuck_low; low_cnt == int'(TIMEOUT_CYC) + 8; endsequence
    sequence s_bus_idle; hi_cnt == 64; endsequence
    sequence s_fault_held; FAULT_ALERT != 0 && fault_cnt == 400; endsequence
    property p_timeout; s_stuck_low |-> sda_oe_n_o; endproperty
    property p_sda_idle; s_bus_idle |-> sda_oe_n_o; endproperty
    property p_fault_alert; s_fault_held |-> !alert_oe_n_o; endproperty
    property p_alert_hold; $rose(alert_oe_n_o) |-> quiet_cnt < 64; endproperty
    property p_alert_od; alert_o == 1'b0; endproperty
    property p_over_od; overtemp_alarm_out_o == 1'b0; endproperty
    property p_sda_od; sda_o == 1'b0; endproperty
    property p_reset_quiet;
        $fell(rst_i) |-> alert_oe_n_o && overtemp_alarm_out_oe_n_o;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("SDA still driven after bus timeout");
    a_sda_idle: assert property (p_sda_idle)
        else $error("SDA driven on idle bus");
    a_fault_alert: assert property (p_fault_alert)
        else $error("Alert not raised on diode fault");
    a_alert_hold: assert property (p_alert_hold)
        else $error("Alert released without bus activity");
    a_alert_od: assert property (p_alert_od)
        else $error("Alert pin drives high");
    a_over_od: assert property (p_over_od)
        else $error("Overtemp pin drives high");
    a_sda_od: assert property (p_sda_od)
        else $error("SDA drives high");
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("Alarm pulled low out of reset");
endmodule
bind dts_sensor dts_sensor_chk #(
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .FAULT_ALERT(FAULT_ALERT)
) u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .local_temp_i(local_temp_i), .remote_temp_i(remote_temp_i),
    .remote_fault_i(remote_fault_i), .alert_o(alert_o),
    .alert_oe_n_o(alert_oe_n_o), .overtemp_alarm_out_o(overtemp_alarm_out_o),
    .overtemp_alarm_out_oe_n_o(overtemp_alarm_out_oe_n_o));
`default_nettype wire

// *** tb/dts_smb_host.sv ***
// SMBus host model driving the sensor's serial pins
`timescale 1ns/1ps
`default_nettype none
module dts_smb_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        sda_low_o = 1'b0;
        hc(2);
        scl_o = 1'b1;
        hc(4);
        sda_low_o = 1'b1;
        hc(4);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        hc(2);
        scl_o = 1'b1;
        hc(4);
        sda_low_o = 1'b0;
        hc(4);
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = !b[i];
            hc(2);
            scl_o = 1'b1;
            hc(3);
            r[i] = sda_i;
            hc(1);
            scl_o = 1'b0;
            hc(2);
        end
    endtask
endmodule
`default_nettype wire

// *** tb/dts_sensor_tb_top.sv ***
// Self-checking bench for the temperature sensor core
`timescale 1ns/1ps
`default_nettype none
module dts_sensor_tb_top;
    localparam logic [6:0] DEV = 7'h4c;
    localparam logic [11:0] CORNER [4] = '{12'd200, 12'd1160, 12'hff8, 12'd7};
    logic        ref_clk_i;
    logic        rst_i;
    logic        scl;
    logic        sda_low;
    logic        rem_fault;
    logic        sda_o;
    logic        sda_oe_n;
    logic        alert_o;
    logic        alert_oe_n;
    logic        ot_o;
    logic        ot_oe_n;
    logic [11:0] lt;
    logic [11:0] rt;
    logic [31:0] seed;
    logic [7:0]  d;
    logic [8:0]  r;
    int          mismatches;
    int          cmp_count;
    wire logic   sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
    dts_sensor #(.TIMEOUT_CYC(2000), .INTEG_CYC(50),
        .PERIOD_CYC(400)) u_dut (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .local_temp_i(lt), .remote_temp_i(rt),
        .remote_fault_i(rem_fault), .alert_o(alert_o),
        .alert_oe_n_o(alert_oe_n), .overtemp_alarm_out_o(ot_o),
        .overtemp_alarm_out_oe_n_o(ot_oe_n));
    dts_smb_host u_host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input bit dat);
        u_host.start();
        u_host.xbyte({DEV, 1'b0, 1'b1}, r);
        u_host.xbyte({a, 1'b1}, r);
        if (dat) u_host.xbyte({v, 1'b1}, r);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] a);
        wr(a, 8'h00, 1'b0);
        u_host.start();
        u_host.xbyte({DEV, 1'b1, 1'b1}, r);
        u_host.xbyte(9'h1ff, r);
        u_host.stop();
        d = r[8:1];
    endtask
    function automatic logic [7:0] e_int(input logic [11:0] t);
        return t[11] ? 8'h00 : t[10:3];
    endfunction
    function automatic logic [2:0] e_frac(input logic [11:0] t);
        return t[11] ? 3'h0 : t[2:0];
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic settle_read();
        u_host.hc(300);
        rd(8'h00);
        chk(d, e_int(lt));
        rd(8'h11);
        chk({d[7:5], 5'h0}, {e_frac(lt), 5'h0});
        rd(8'h01);
        chk(d, rem_fault ? 8'hff : e_int(rt));
        rd(8'h10);
        chk({d[7:5], 5'h0}, {rem_fault ? 3'h0 : e_frac(rt), 5'h0});
    endtask
    task automatic summarize();
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        mismatches++;
        summarize();
    end
    initial begin
        rst_i = 1'b1;
        lt = 12'h0;
        rt = 12'h0;
        rem_fault = 1'b0;
        seed = 32'd98;
        repeat (3) @(negedge ref_clk_i);
        rst_i = 1'b0;
        u_host.hc(3);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            lt = (i < 4) ? CORNER[i] : {1'b0, seed[10:0]};
            rt = (i < 4) ? CORNER[3 - i] : {1'b0, seed[26:16]};
            settle_read();
        end
        lt = 12'd240;
        rt = 12'd240;
        rem_fault = 1'b1;
        settle_read();
        chk({7'h0, alert_oe_n}, 8'h00);
        rem_fault = 1'b0;
        u_host.hc(300);
        chk({7'h0, alert_oe_n}, 8'h00);
        rd(8'h02);
        chk({7'h0, alert_oe_n}, 8'h01);
        chk({7'h0, ot_oe_n}, 8'h01);
        lt = 12'd720;
        u_host.hc(300);
        chk({7'h0, alert_oe_n}, 8'h00);
        chk({7'h0, ot_oe_n}, 8'h00);
        lt = 12'd680;
        u_host.hc(300);
        chk({7'h0, ot_oe_n}, 8'h01);
        rd(8'h02);
        chk({7'h0, alert_oe_n}, 8'h00);
        lt = 12'd240;
        u_host.hc(300);
        rd(8'h02);
        chk({7'h0, alert_oe_n}, 8'h01);
        wr(8'h06, 8'h14, 1'b1);
        lt = 12'd80;
        u_host.hc(300);
        chk({7'h0, alert_oe_n}, 8'h00);
        // Cause gone, alarm still latched: alert response returns our address
        lt = 12'd240;
        u_host.hc(300);
        u_host.start();
        u_host.xbyte({7'h0c, 1'b1, 1'b1}, r);
        u_host.xbyte(9'h1ff, r);
        u_host.stop();
        chk(r[8:1], {DEV, 1'b1});
        chk({7'h0, alert_oe_n}, 8'h01);
        // Standby: results must hold until a single conversion is requested
        wr(8'h03, 8'h40, 1'b1);
        u_host.hc(300);
        lt = 12'd400;
        u_host.hc(300);
        rd(8'h00);
        chk(d, e_int(12'd240));
        wr(8'h0f, 8'h00, 1'b0);
        settle_read();
        // Stall SCL low while the sensor drives a zero data bit
        u_host.start();
        u_host.xbyte({DEV, 1'b1, 1'b1}, r);
        u_host.hc(2100);
        chk({7'h0, sda}, 8'h01);
        u_host.stop();
        summarize();
    end
endmodule
`default_nettype wire
